/* src/scs_pkg.sv */
// shared constants and types for the streaming configuration host
// assumes a 50 MHz system clock; all pin timing is derived from it
package scs_pkg;

    // system clock period in ns
    localparam int CLK_PERIOD_NS  = 20;
    // ceiling on the data clock the host may drive, in MHz
    localparam int DCLK_MAX_MHZ   = 125;
    // least data clock divider that keeps under that ceiling, never below 2
    localparam int DCLK_MIN_DIV   =
        (1000 + DCLK_MAX_MHZ * CLK_PERIOD_NS - 1) /
        (DCLK_MAX_MHZ * CLK_PERIOD_NS) < 2 ? 2 :
        (1000 + DCLK_MAX_MHZ * CLK_PERIOD_NS - 1) /
        (DCLK_MAX_MHZ * CLK_PERIOD_NS);
    // default divider: 4 system clocks give an 80 ns data clock
    localparam int DCLK_DIV_DEF   = 4;
    // width of the divider counter
    localparam int DIV_W          = 4;

    // length of each phase of the reset pin sequence, in ns
    localparam int NCFG_PHASE_NS  = 1000;
    // the same as a least count, rounded up
    localparam int NCFG_PHASE_CYC =
        (NCFG_PHASE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    // default wait for the status pin to rise, in cycles (2 ms)
    localparam int STATUS_WAIT_DEF = 100000;
    // width of the phase timer
    localparam int TMR_W          = 17;

    // words the device tolerates after it drops ready
    localparam int MAX_OVERRUN    = 6;

    // scheme select patterns driven toward the mode pins
    localparam logic [2:0] SCHEME_X32 = 3'h0;
    localparam logic [2:0] SCHEME_X16 = 3'h5;
    localparam logic [2:0] SCHEME_X8  = 3'h6;

    // byte lane enables per width
    localparam logic [3:0] LANES_X32  = 4'hf;
    localparam logic [3:0] LANES_X16  = 4'h3;
    localparam logic [3:0] LANES_X8   = 4'h1;

    // index of the last byte in a word per width
    localparam logic [1:0] LAST_X32   = 2'h3;
    localparam logic [1:0] LAST_X16   = 2'h1;
    localparam logic [1:0] LAST_X8    = 2'h0;

    // user-side width selection
    typedef enum logic [1:0] {
        SCS_W32,
        SCS_W16,
        SCS_W8
    } scs_width_e;

    // controller sequence
    typedef enum logic [2:0] {
        ST_IDLE,
        ST_PRE_HIGH,
        ST_PULSE_LOW,
        ST_WAIT_STATUS,
        ST_STREAM,
        ST_DONE,
        ST_FAIL
    } scs_state_e;

endpackage

/* src/scs_sync.sv */
// two-flop synchroniser for a group of independent level inputs
// assumes each bit is a slow level; no bus coherence across bits
`timescale 1ns/10ps
`default_nettype none
module scs_sync #(
    parameter int W = 1
) (
    input  wire logic         clk,
    input  wire logic         rst_n,
    input  wire logic [W-1:0] d,
    output logic      [W-1:0] q
);
    // stage1 feeds stage2 only, nothing else looks at it
    typedef struct packed {
        logic [W-1:0] stage1;  // first catch, may be metastable
        logic [W-1:0] stage2;  // settled copy
    } scs_sync_s;

    scs_sync_s sync_ff;
    scs_sync_s nxt_sync;

    // shift the pin through both stages
    always_comb begin
        nxt_sync        = sync_ff;
        nxt_sync.stage1 = d;
        nxt_sync.stage2 = sync_ff.stage1;
    end

    // synchronous reset to zero
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            sync_ff <= '0;
        end else begin
            sync_ff <= nxt_sync;
        end
    end

    assign q = sync_ff.stage2;
endmodule // scs_sync
`default_nettype wire

/* src/scs_fifo.sv */
// small fifo with a registered read stage and a registered ready
// assumes DEPTH is a power of two; both sides on one clock
`timescale 1ns/10ps
`default_nettype none
module scs_fifo #(
    parameter int W     = 8,
    parameter int DEPTH = 8
) (
    input  wire logic         clk,
    input  wire logic         rst_n,
    input  wire logic [W-1:0] in_data,
    input  wire logic         in_valid,
    output logic              in_ready,
    output logic      [W-1:0] out_data,
    output logic              out_valid,
    input  wire logic         out_ready
);
    localparam int PW = $clog2(DEPTH);
    localparam int CW = $clog2(DEPTH + 1);

    typedef struct packed {
        logic [DEPTH-1:0][W-1:0] mem;  // storage
        logic [PW-1:0]           wp;   // write pointer
        logic [PW-1:0]           rp;   // read pointer
        logic [CW-1:0]           cnt;  // words held in storage
        logic                    rdy;  // room for one more
        logic [W-1:0]            od;   // registered read data
        logic                    ov;   // read stage holds a word
    } scs_fifo_s;

    scs_fifo_s fifo_ff;
    scs_fifo_s nxt_fifo;

    // push, refill the read stage, and track occupancy
    always_comb begin
        logic push;
        logic pop;
        push     = 1'b0;
        pop      = 1'b0;
        nxt_fifo = fifo_ff;
        push     = in_valid && fifo_ff.rdy;
        // refill the read stage when empty or being drained
        pop      = (fifo_ff.cnt != '0) && (!fifo_ff.ov || out_ready);
        if (fifo_ff.ov && out_ready) begin
            nxt_fifo.ov = 1'b0;
        end
        if (pop) begin
            nxt_fifo.od = fifo_ff.mem[fifo_ff.rp];
            nxt_fifo.ov = 1'b1;
            nxt_fifo.rp = fifo_ff.rp + 1'b1;
        end
        if (push) begin
            nxt_fifo.mem[fifo_ff.wp] = in_data;
            nxt_fifo.wp              = fifo_ff.wp + 1'b1;
        end
        unique case ({push, pop})
            2'b10:   nxt_fifo.cnt = fifo_ff.cnt + 1'b1;
            2'b01:   nxt_fifo.cnt = fifo_ff.cnt - 1'b1;
            default: nxt_fifo.cnt = fifo_ff.cnt;
        endcase
        // registered ready so the source sees a clean level
        nxt_fifo.rdy = (nxt_fifo.cnt != CW'(DEPTH));
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            fifo_ff     <= '0;
            fifo_ff.rdy <= 1'b1;
        end else begin
            fifo_ff <= nxt_fifo;
        end
    end

    assign in_ready  = fifo_ff.rdy;
    assign out_data  = fifo_ff.od;
    assign out_valid = fifo_ff.ov;
endmodule // scs_fifo
`default_nettype wire

/* src/scs_host.sv */
// host controller that loads a configuration bitstream into the device
// over its streaming port; bytes arrive from the user side, are packed
// little-endian into words and pushed out on a divided data clock.
// assumes the device pins are asynchronous to clk; no register bus.
`timescale 1ns/10ps
`default_nettype none
module scs_host #(
    parameter int DCLK_DIV     = scs_pkg::DCLK_DIV_DEF,
    parameter int STATUS_WAIT  = scs_pkg::STATUS_WAIT_DEF,
    parameter int FIFO_DEPTH   = 8
) (
    input  wire logic        clk,
    input  wire logic        rst_n,
    // user side
    input  wire logic        start,
    input  wire logic [1:0]  width_sel,
    input  wire logic [7:0]  usr_byte,
    input  wire logic        usr_valid,
    output logic             usr_ready,
    output logic             busy,
    output logic             done,
    output logic             fail,
    // device pins
    output logic             cfg_nconfig,
    input  wire logic        cfg_nstatus,
    input  wire logic        cfg_conf_done,
    input  wire logic        cfg_ready,
    output logic             cfg_data_clk,
    output logic      [31:0] cfg_data,
    output logic      [3:0]  cfg_lane_oe,
    output logic             cfg_word_valid,
    output logic      [2:0]  scheme_select
);
    // divider must not drive the data clock above its ceiling
    localparam int DIV_USE  = DCLK_DIV < scs_pkg::DCLK_MIN_DIV ?
                              scs_pkg::DCLK_MIN_DIV : DCLK_DIV;
    localparam int DIV_HALF = DIV_USE / 2;

    localparam logic [scs_pkg::DIV_W-1:0] DIV_LAST =
        scs_pkg::DIV_W'(DIV_USE - 1);
    localparam logic [scs_pkg::DIV_W-1:0] DIV_HI   =
        scs_pkg::DIV_W'(DIV_HALF);
    localparam logic [scs_pkg::TMR_W-1:0] PHASE_CYC =
        scs_pkg::TMR_W'(scs_pkg::NCFG_PHASE_CYC);
    localparam logic [scs_pkg::TMR_W-1:0] WAIT_CYC  =
        scs_pkg::TMR_W'(STATUS_WAIT);

    // whole controller state in one record
    typedef struct packed {
        scs_pkg::scs_state_e       st;      // sequence state
        logic [scs_pkg::TMR_W-1:0] tmr;     // phase timer, counts down
        logic [scs_pkg::DIV_W-1:0] div;     // data clock divider
        logic                      dclk;    // data clock pin
        logic                      ncfg;    // reset pin, active low
        logic [2:0]                scheme;  // mode pattern on the pins
        logic [1:0]                last;    // index of final byte
        logic [3:0]                oe;      // byte lane enables
        logic [31:0]               data;    // data bus toward device
        logic                      valid;   // word strobe
        logic [31:0]               pack;    // word being assembled
        logic [1:0]                nb;      // next byte lane
        logic                      full;    // packed word ready to go
        logic                      busy;    // sequence running
        logic                      done;    // loaded, sticky
        logic                      fail;    // error, sticky
    } scs_host_s;

    scs_host_s host_ff;
    scs_host_s nxt_host;

    // synchronised pins: ready, status, done
    logic [2:0] pin_sync;
    logic       ready_sync_stage2;  // settled ready
    logic       nstatus_s;          // settled status, active low pin
    logic       conf_done_s;        // settled completion flag

    // fifo read side
    logic [7:0] fifo_byte;
    logic       fifo_valid;
    logic       fifo_pop_ok;

    // ready is asynchronous to everything here, so it is only ever read
    // after two flops; status and done share the same synchroniser
    scs_sync #(
        .W (3)
    ) u_sync (
        .clk   (clk),
        .rst_n (rst_n),
        .d     ({cfg_ready, cfg_nstatus, cfg_conf_done}),
        .q     (pin_sync)
    );

    assign ready_sync_stage2 = pin_sync[2];
    assign nstatus_s         = pin_sync[1];
    assign conf_done_s       = pin_sync[0];

    // byte buffer between the user side and the packer; its ready is
    // the user's back-pressure, so a stalled device fills it for real
    scs_fifo #(
        .W     (8),
        .DEPTH (FIFO_DEPTH)
    ) u_fifo (
        .clk       (clk),
        .rst_n     (rst_n),
        .in_data   (usr_byte),
        .in_valid  (usr_valid),
        .in_ready  (usr_ready),
        .out_data  (fifo_byte),
        .out_valid (fifo_valid),
        .out_ready (fifo_pop_ok)
    );

    // the packer takes a byte only while streaming and not holding a word
    assign fifo_pop_ok = (host_ff.st == scs_pkg::ST_STREAM) &&
                         !host_ff.full;

    // sequence, divider, packer and launcher
    always_comb begin
        logic tick;
        logic ready_ok;
        tick     = 1'b0;
        ready_ok = 1'b0;
        nxt_host = host_ff;

        // free-running divider while configuring; the word changes at
        // the falling edge so it is steady around the rising edge
        if (host_ff.busy) begin
            tick          = (host_ff.div == DIV_LAST);
            nxt_host.div  = tick ? '0 : host_ff.div + 1'b1;
            nxt_host.dclk = (nxt_host.div >= DIV_HI);
        end else begin
            // clock parked once done or idle, allowed after completion
            nxt_host.div  = '0;
            nxt_host.dclk = 1'b0;
        end

        // ready only counts while status is high
        ready_ok = ready_sync_stage2 && nstatus_s;

        unique case (host_ff.st)
            scs_pkg::ST_IDLE,
            scs_pkg::ST_DONE,
            scs_pkg::ST_FAIL: begin
                nxt_host.ncfg  = 1'b1;
                nxt_host.valid = 1'b0;
                nxt_host.oe    = '0;
                if (start) begin
                    // latch width and begin the reset pin sequence high
                    nxt_host.st   = scs_pkg::ST_PRE_HIGH;
                    nxt_host.tmr  = PHASE_CYC;
                    nxt_host.busy = 1'b1;
                    nxt_host.done = 1'b0;
                    nxt_host.fail = 1'b0;
                    nxt_host.full = 1'b0;
                    nxt_host.nb   = '0;
                    nxt_host.pack = '0;
                    nxt_host.data = '0;
                    unique case (width_sel)
                        scs_pkg::SCS_W16: begin
                            nxt_host.scheme = scs_pkg::SCHEME_X16;
                            nxt_host.last   = scs_pkg::LAST_X16;
                            nxt_host.oe     = scs_pkg::LANES_X16;
                        end
                        scs_pkg::SCS_W8: begin
                            nxt_host.scheme = scs_pkg::SCHEME_X8;
                            nxt_host.last   = scs_pkg::LAST_X8;
                            nxt_host.oe     = scs_pkg::LANES_X8;
                        end
                        default: begin
                            // code 3 is unused and falls back to x32
                            nxt_host.scheme = scs_pkg::SCHEME_X32;
                            nxt_host.last   = scs_pkg::LAST_X32;
                            nxt_host.oe     = scs_pkg::LANES_X32;
                        end
                    endcase
                end
            end

            scs_pkg::ST_PRE_HIGH: begin
                // hold the reset pin high for one phase
                nxt_host.ncfg = 1'b1;
                if (host_ff.tmr == '0) begin
                    nxt_host.st   = scs_pkg::ST_PULSE_LOW;
                    nxt_host.tmr  = PHASE_CYC;
                    nxt_host.ncfg = 1'b0;
                end else begin
                    nxt_host.tmr = host_ff.tmr - 1'b1;
                end
            end

            scs_pkg::ST_PULSE_LOW: begin
                // low phase clears the device, then release high
                if (host_ff.tmr == '0) begin
                    nxt_host.st   = scs_pkg::ST_WAIT_STATUS;
                    nxt_host.tmr  = WAIT_CYC;
                    nxt_host.ncfg = 1'b1;
                end else begin
                    nxt_host.tmr = host_ff.tmr - 1'b1;
                end
            end

            scs_pkg::ST_WAIT_STATUS: begin
                // the device must raise status before ready means anything
                if (nstatus_s) begin
                    nxt_host.st = scs_pkg::ST_STREAM;
                end else if (host_ff.tmr == '0) begin
                    nxt_host.st   = scs_pkg::ST_FAIL;
                    nxt_host.fail = 1'b1;
                    nxt_host.busy = 1'b0;
                    nxt_host.oe   = '0;
                end else begin
                    nxt_host.tmr = host_ff.tmr - 1'b1;
                end
            end

            scs_pkg::ST_STREAM: begin
                // take one byte into its little-endian lane
                if (fifo_valid && !host_ff.full) begin
                    nxt_host.pack[{host_ff.nb, 3'h0} +: 8] =
                        fifo_byte;
                    if (host_ff.nb == host_ff.last) begin
                        nxt_host.full = 1'b1;
                        nxt_host.nb   = '0;
                    end else begin
                        nxt_host.nb = host_ff.nb + 1'b1;
                    end
                end
                // launch at the falling edge: a whole word and a seen
                // ready; the decision is remade every data clock, so at
                // most about two words go out after ready falls
                if (tick) begin
                    if (host_ff.full && ready_ok) begin
                        nxt_host.data  = host_ff.pack;
                        nxt_host.valid = 1'b1;
                        nxt_host.full  = 1'b0;
                        nxt_host.pack  = '0;
                    end else begin
                        nxt_host.valid = 1'b0;
                    end
                end
                // completion or a status drop ends the stream
                if (conf_done_s) begin
                    nxt_host.st    = scs_pkg::ST_DONE;
                    nxt_host.done  = 1'b1;
                    nxt_host.busy  = 1'b0;
                    nxt_host.valid = 1'b0;
                    nxt_host.oe    = '0;
                end else if (!nstatus_s) begin
                    nxt_host.st    = scs_pkg::ST_FAIL;
                    nxt_host.fail  = 1'b1;
                    nxt_host.busy  = 1'b0;
                    nxt_host.valid = 1'b0;
                    nxt_host.oe    = '0;
                end
            end

            default: begin
                // illegal code: park safely
                nxt_host.st   = scs_pkg::ST_IDLE;
                nxt_host.busy = 1'b0;
            end
        endcase
        // park the clock in the very cycle busy drops
        if (!nxt_host.busy) begin
            nxt_host.dclk = 1'b0;
        end
    end

    // state register, synchronous reset; reset pin idles high
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            host_ff        <= '0;
            host_ff.st     <= scs_pkg::ST_IDLE;
            host_ff.ncfg   <= 1'b1;
            host_ff.scheme <= scs_pkg::SCHEME_X32;
            host_ff.last   <= scs_pkg::LAST_X32;
        end else begin
            host_ff <= nxt_host;
        end
    end

    // every output except usr_ready straight from the state record
    assign cfg_nconfig    = host_ff.ncfg;
    assign cfg_data_clk   = host_ff.dclk;
    assign cfg_data       = host_ff.data;
    assign cfg_lane_oe    = host_ff.oe;
    assign cfg_word_valid = host_ff.valid;
    assign scheme_select  = host_ff.scheme;
    assign busy           = host_ff.busy;
    assign done           = host_ff.done;
    assign fail           = host_ff.fail;
endmodule // scs_host
`default_nettype wire

/* test/scs_cfg_dev.sv */
// behavioural model of the device side of the streaming config port
// assumes host pins are sampled on the 50 MHz bench clock
`timescale 1ns/10ps
`default_nettype none
module scs_cfg_dev (
    input  wire logic        clk,
    input  wire logic        cfg_nconfig,
    input  wire logic        cfg_data_clk,
    input  wire logic [31:0] cfg_data,
    input  wire logic        cfg_word_valid,
    input  wire logic        stall,
    input  wire logic        mute,
    input  wire logic [7:0]  total,
    output logic             cfg_nstatus,
    output logic             cfg_conf_done,
    output logic             cfg_ready
);
    logic [31:0] mem_ff [0:63]; // captured words in arrival order
    int          cnt_ff = 0;    // words captured since clearing
    int          ovr_ff = 0;    // words taken since ready fell
    int          ovr_max_ff = 0;
    int          wake_ff = 0;   // cycles since the reset pin rose
    int          idle_ff = 0;   // cycles since the data clock moved
    logic        dclk_ff = 1'b0;
    logic        stat_ff = 1'b0;

    // pause comes from the bench clock; ready also drops once the data clock has sat still for 8 cycles
    assign cfg_ready = stat_ff & ~stall & ~cfg_conf_done
                     & (idle_ff < 8);
    assign cfg_nstatus = stat_ff;
    assign cfg_conf_done = stat_ff & (cnt_ff >= total);

    // clearing, status wake-up and word capture
    always @(posedge clk) begin
        dclk_ff <= cfg_data_clk;
        idle_ff <= (cfg_data_clk != dclk_ff) ? 0 : idle_ff + 1;
        if (cfg_ready) ovr_ff <= 0;
        if (!cfg_nconfig) begin // count and status cleared on the low phase
            wake_ff    <= 0;
            stat_ff    <= 1'b0;
            cnt_ff     <= 0;
            ovr_max_ff <= 0;
        end else begin
            wake_ff <= wake_ff + 1;
            if (wake_ff == 20 && !mute) stat_ff <= 1'b1;
        end
        // one word per rising data clock with valid high
        if (cfg_data_clk && !dclk_ff && cfg_word_valid && stat_ff) begin
            mem_ff[cnt_ff] <= cfg_data;
            cnt_ff         <= cnt_ff + 1;
            if (!cfg_ready) begin // overrun words still land
                ovr_ff <= ovr_ff + 1;
                if (ovr_ff + 1 > ovr_max_ff) ovr_max_ff <= ovr_ff + 1;
            end
        end
    end
endmodule // scs_cfg_dev
`default_nettype wire

/* test/scs_host_checker.sv */
// concurrent checks on the pins of the configuration host
// assumes the default divider of 4 and one clock domain
`timescale 1ns/10ps
`default_nettype none
module scs_host_checker (
    input wire logic        clk,
    input wire logic        rst_n,
    input wire logic        start,
    input wire logic [1:0]  width_sel,
    input wire logic [7:0]  usr_byte,
    input wire logic        usr_valid,
    input wire logic        usr_ready,
    input wire logic        busy,
    input wire logic        done,
    input wire logic        fail,
    input wire logic        cfg_nconfig,
    input wire logic        cfg_nstatus,
    input wire logic        cfg_conf_done,
    input wire logic        cfg_ready,
    input wire logic        cfg_data_clk,
    input wire logic [31:0] cfg_data,
    input wire logic [3:0]  cfg_lane_oe,
    input wire logic        cfg_word_valid,
    input wire logic [2:0]  scheme_select
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);
    logic       dclk_ff;    // data clock one cycle back
    logic [7:0] ncf_cnt_ff; // cycles since the reset pin moved
    logic [3:0] ovr_cnt_ff; // words launched while ready is low
    wire  logic launch = dclk_ff & ~cfg_data_clk & cfg_word_valid;

    // helper counters; the reset pin counter saturates so a long idle never wraps
    always_ff @(posedge clk) begin
        dclk_ff <= cfg_data_clk;
        if (!rst_n) begin
            ncf_cnt_ff <= 8'h0;
            ovr_cnt_ff <= 4'h0;
        end else begin
            ncf_cnt_ff <= $changed(cfg_nconfig) ? 8'h0
                        : ncf_cnt_ff + {7'h0, ~&ncf_cnt_ff};
            ovr_cnt_ff <= cfg_ready ? 4'h0 : ovr_cnt_ff + {3'h0, launch};
        end
    end

    scheme_map_a: assert property (start && !busy |=> busy &&
        scheme_select == ($past(width_sel) == 2'h1 ? scs_pkg::SCHEME_X16
        : $past(width_sel) == 2'h2 ? scs_pkg::SCHEME_X8
        : scs_pkg::SCHEME_X32)) else $error("scheme pins wrong");
    lane_map_a: assert property (busy |-> cfg_lane_oe ==
        (scheme_select == 3'h5 ? 4'h3 : scheme_select == 3'h6 ? 4'h1
        : 4'hf)) else $error("lane enables wrong");
    idle_quiet_a: assert property (!busy |-> cfg_lane_oe == 4'h0 &&
        !cfg_word_valid && !cfg_data_clk) else $error("pins not idle");
    rst_phase_a: assert property ($changed(cfg_nconfig) |->
        ncf_cnt_ff >= scs_pkg::NCFG_PHASE_CYC - 3)
        else $error("reset pin phase short");
    rst_busy_a: assert property (!cfg_nconfig |-> busy)
        else $error("reset pin low when idle");
    dclk_high_a: assert property ($rose(cfg_data_clk) && busy |=>
        (cfg_data_clk || !busy) ##1 !cfg_data_clk)
        else $error("data clock high phase");
    dclk_low_a: assert property ($fell(cfg_data_clk) && busy |=>
        !cfg_data_clk ##1 (cfg_data_clk || !busy))
        else $error("data clock low phase");
    word_hold_a: assert property (cfg_data_clk |->
        $stable(cfg_data) && $stable(cfg_word_valid))
        else $error("word moved while clock high");
    ready_gate_a: assert property (launch |->
        ($past(cfg_ready, 3) && $past(cfg_nstatus, 3)) ||
        ($past(cfg_ready, 4) && $past(cfg_nstatus, 4)))
        else $error("word without ready");
    overrun_a: assert property (ovr_cnt_ff <= scs_pkg::MAX_OVERRUN)
        else $error("too many words after ready fell");
    done_seen_a: assert property ($rose(cfg_conf_done) && busy |->
        ##[1:6] done) else $error("done not reported");
    cover property (launch && scheme_select == scs_pkg::SCHEME_X8);
    cover property (launch && !cfg_ready);
    cover property ($rose(fail));
endmodule // scs_host_checker
bind scs_host scs_host_checker u_chk (.*);
`default_nettype wire

/* test/test_scs_host.sv */
// self-checking bench: host controller against the device model
// assumes the bench drives all inputs on the rising clock edge
`timescale 1ns/10ps
`default_nettype none
module test_scs_host;
    logic        clk = 1'b0;
    logic        rst_n = 1'b0;
    logic        start = 1'b0;
    logic [1:0]  width_sel = 2'h0;
    logic [7:0]  usr_byte = 8'h0;
    logic        usr_valid = 1'b0;
    logic        stall = 1'b0;   // device decompression pause
    logic        mute = 1'b0;    // device status never rises
    logic [7:0]  total = 8'h0;   // words the device waits for
    logic        usr_ready, busy, done, fail, cfg_nconfig, cfg_ready;
    logic        cfg_nstatus, cfg_conf_done, cfg_data_clk, cfg_word_valid;
    logic [31:0] cfg_data;
    logic [3:0]  cfg_lane_oe;
    logic [2:0]  scheme_select;
    logic [7:0]  bytes [0:63];   // bitstream of the current load
    int          fail_count = 0;
    int          cmp_count = 0;
    int          seed = 64954;
    int          cycles = 0;
    bit          stir = 1'b0;    // random pauses enabled

    scs_host #(.DCLK_DIV(4), .STATUS_WAIT(200)) u_dut (.*);
    scs_cfg_dev u_dev (.*);

    initial forever #10 clk = ~clk;

    // random ready pauses, long enough to provoke overrun words
    always @(posedge clk)
        if (!stir) stall <= 1'b0;
        else if (($random(seed) & 15) == 0) stall <= ~stall;

    // hang guard
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            fail_count++;
            summarize();
        end
    end

    task automatic check(input string what, input logic [31:0] seen, exp);
        cmp_count++;
        if (seen !== exp) begin
            fail_count++;
            $display("[ERR] %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic summarize();
        $display("comparisons %0d mismatches %0d", cmp_count, fail_count);
        if (fail_count == 0 && cmp_count > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask

    // bytes per word of a width code; code 3 behaves as 32 bits
    function automatic int bpw(input logic [1:0] w);
        return (w == 2'h1) ? 2 : (w == 2'h2) ? 1 : 4;
    endfunction

    // little-endian packing: first byte lands in the low lane
    function automatic logic [31:0] exp_word(input logic [1:0] w, int i);
        logic [31:0] v;
        v = 32'h0;
        for (int k = 0; k < bpw(w); k++) v[8*k +: 8] = bytes[i*bpw(w) + k];
        return v;
    endfunction

    // one full load of nw words at width w, with random gaps and pauses
    task automatic load(input logic [1:0] w, input int nw);
        int t;
        for (int k = 0; k < 64; k++) bytes[k] = 8'($random(seed));
        {bytes[0], bytes[1], bytes[2], bytes[3]} = 32'h021bee01;
        width_sel <= w;
        start     <= 1'b1;
        total     <= nw[7:0];
        @(posedge clk);
        start <= 1'b0;
        stir  <= 1'b1;
        fork
            for (int k = 0; k < nw * bpw(w); k++) begin
                usr_byte  <= bytes[k];
                usr_valid <= 1'b1;
                do @(posedge clk); while (usr_ready !== 1'b1);
                if (k == nw * bpw(w) - 1 || ($random(seed) & 1)) begin
                    usr_valid <= 1'b0;
                    @(posedge clk);
                end
            end
            begin
                @(negedge cfg_nconfig);
                @(posedge clk);
                check("fifo full", usr_ready, 1'b0);
                check("early word", cfg_word_valid, 1'b0);
                for (t = 0; t < 6000 && done !== 1'b1; t++) @(posedge clk);
            end
        join
        usr_valid <= 1'b0;
        stir      <= 1'b0;
        check("done", done, 1'b1);
        check("fail", fail, 1'b0);
        check("scheme", scheme_select,
              w == 2'h1 ? 3'h5 : w == 2'h2 ? 3'h6 : 3'h0);
        check("count", u_dev.cnt_ff, nw);
        check("overrun", u_dev.ovr_max_ff <= scs_pkg::MAX_OVERRUN, 1);
        for (int i = 0; i < nw; i++) begin
            check("word", u_dev.mem_ff[i], exp_word(w, i));
        end
        @(posedge clk);
        check("lanes off", cfg_lane_oe, 4'h0);
        $display("load width code %0d words %0d finished", w, nw);
    endtask

    initial begin
        int t;
        repeat (10) @(posedge clk);
        rst_n <= 1'b1;
        for (int w = 0; w < 4; w++) load(w[1:0], 10 + ($random(seed) & 3));
        mute  <= 1'b1;
        start <= 1'b1;
        @(posedge clk);
        start <= 1'b0;
        for (t = 0; t < 600 && fail !== 1'b1; t++) @(posedge clk);
        check("status timeout", fail, 1'b1);
        check("no words", u_dev.cnt_ff, 0);
        $display("status timeout test finished");
        mute <= 1'b0;
        @(posedge clk);
        load(2'($random(seed)), 12);
        summarize();
    end
endmodule // test_scs_host
`default_nettype wire
